// ### tb/gei_pin_src.sv
// Model of the external signal sources in front of the unit's pins
`timescale 1ns/100ps
module gei_pin_src
    import gei_pkg::*;
(
    input  wire logic                         clk_i,
    output logic [gei_pkg::NUM_PINS-1:0]      pin_o,
    output logic [gei_pkg::NUM_PINS-1:0]      analog_o
);
    // Sources idle low, no pin analog
    initial begin
        pin_o    = 40'h0;
        analog_o = 40'h0;
    end
    // Levels change just after an edge so the unit never samples mid-change
    task automatic drive(input logic [NUM_PINS-1:0] lvl, input logic [NUM_PINS-1:0] ana);
        @(posedge clk_i);
        pin_o    <= lvl;
        analog_o <= ana;
    endtask
endmodule // gei_pin_src

// ### tb/gei_properties.sv
// Concurrent checks on the ports of the external interrupt unit
`timescale 1ns/100ps
module gei_properties
    import gei_pkg::*;
(
    input wire logic                         clk_i,
    input wire logic                         rst_i,
    input wire logic                         cyc_i,
    input wire logic                         stb_i,
    input wire logic                         we_i,
    input wire logic [7:0]                   adr_i,
    input wire logic [3:0]                   sel_i,
    input wire logic [31:0]                  dat_i,
    input wire logic [31:0]                  dat_o,
    input wire logic                         ack_o,
    input wire logic [gei_pkg::NUM_PINS-1:0] pin_in_i,
    input wire logic [gei_pkg::NUM_PINS-1:0] pin_analog_i,
    input wire logic [gei_pkg::NUM_SRC-1:0]  vec_req_o,
    input wire logic                         int_o
);
    // Shadow source 0 config and mask so checks know the mode without seeing inside
    logic       take;
    logic       wr0;
    logic       p0;
    logic [3:0] cfg0_ff;
    logic [3:0] mask_ff;
    assign take = cyc_i && stb_i && !ack_o;
    assign wr0  = take && we_i && sel_i[0];
    assign p0   = pin_in_i[PORT_B_PIN_0_IDX] && !pin_analog_i[PORT_B_PIN_0_IDX];
    // Updated on the take edge, as the unit does
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg0_ff <= 4'h0;
            mask_ff <= 4'h0;
        end else begin
            if (wr0 && adr_i == CFG0_OFS) cfg0_ff <= dat_i[3:0];
            if (wr0 && adr_i == EVMASK_OFS) mask_ff <= dat_i[3:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (take |=> ack_o) else $error("ack missing");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    // Only a read reloads dat_o; a write leaves the last read value standing
    a_unmapped_zero: assert property (ack_o && !$past(we_i) && $past(adr_i) == 8'h30 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_rise_latency: assert property (cfg0_ff == 4'h1 && p0 && $rose(pin_in_i[8]) |-> ##2 vec_req_o[0])
        else $error("rising edge not flagged in time");
    a_level_holds: assert property ((cfg0_ff == 4'h4 && p0)[*4] |-> vec_req_o[0])
        else $error("active level not flagged");
    // Pin quiet before the clear edge, so no new edge can win over the clear; later edges may flag again
    a_flag_clear: assert property (wr0 && adr_i == FLAG_OFS && dat_i[0] && cfg0_ff == 4'h1
        && $past(p0) == $past(p0, 2) |-> ##1 !vec_req_o[0]) else $error("flag clear ignored");
    a_disabled_quiet: assert property ((cfg0_ff[2:0] == 3'h0)[*2] |-> !vec_req_o[0])
        else $error("request while disabled");
    a_mask_quiet: assert property (mask_ff == 4'h0 |-> !int_o) else $error("interrupt while masked");
endmodule // gei_properties

// ### tb/tb.sv
// Self-checking bench for the external interrupt unit
`timescale 1ns/100ps
module tb;
    import gei_pkg::*;
    logic                clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, int_o;
    logic [7:0]          adr_i;
    logic [3:0]          sel_i;
    logic [31:0]         dat_i, dat_o;
    logic [NUM_PINS-1:0] pin_in_i, pin_analog_i;
    logic [NUM_SRC-1:0]  vec_req_o;
    int                  err_count, num_checks;

    gei_top u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
                   .pin_in_i, .pin_analog_i, .vec_req_o, .int_o);
    gei_pin_src u_src (.clk_i, .pin_o(pin_in_i), .analog_o(pin_analog_i));

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; waits as long as ack takes, only the watchdog ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        // Ack stands in the cycle after the take edge, so it is seen at the second edge
        check("ack_wait", 32'(n), 32'h2);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(nm, q, e);
    endtask

    // Configure a source, clear all flags, let the pins act, then read the flags
    task automatic arm(input logic [7:0] a, input logic [31:0] cfg, input logic [31:0] e, input string nm);
        wr(a, cfg);
        wr(FLAG_OFS, 32'hf);
        repeat (4) @(posedge clk_i);
        rd_chk(nm, FLAG_OFS, e);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 12; i++) rd_chk("reset", 8'(i * 4), 32'h0);
        wr(8'h30, 32'hffffffff);
        rd_chk("unmapped", 8'h30, 32'h0);
        sel_i <= 4'he;
        wr(CFG0_OFS, 32'h4);
        sel_i <= 4'hf;
        rd_chk("sel_off", CFG0_OFS, 32'h0);
        $display("reset test done");
    endtask

    // Flag and request of source 0 against a per-mode table, bit m for mode m
    task automatic probe(input int m, input logic [7:0] tbl, input logic clr);
        if (clr) wr(FLAG_OFS, 32'hf);
        repeat (4) @(posedge clk_i);
        rd_chk("mode_flag", FLAG_OFS, {31'h0, tbl[m]});
        check("mode_vec", {28'h0, vec_req_o}, {31'h0, tbl[m] && m inside {[1:5]}});
    endtask

    // Each mode, including the unused codes 6 and 7, through low, rise, clear, fall
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            u_src.drive(40'h0, 40'h0);
            wr(CFG0_OFS, 32'(m));
            probe(m, 8'h20, 1'b1);
            u_src.drive(40'h100, 40'h0);
            probe(m, 8'h3a, 1'b0);
            probe(m, 8'h10, 1'b1);
            u_src.drive(40'h0, 40'h0);
            probe(m, 8'h3c, 1'b0);
        end
        wr(CFG0_OFS, 32'h0);
        $display("mode test done");
    endtask

    // Source, select code, pin driven high, whether it must flag
    task automatic t_select();
        int t [9][4] = '{'{1, 0, 14, 1}, '{2, 0, 0, 1}, '{2, 25, 25, 1}, '{2, 35, 35, 1}, '{2, 24, 24, 0},
                         '{3, 15, 15, 1}, '{3, 32, 32, 1}, '{3, 29, 29, 0}, '{3, 36, 36, 0}};
        for (int i = 0; i < 9; i++) begin
            if (t[i][0] == 2) wr(SELC_OFS, 32'(t[i][1]));
            if (t[i][0] == 3) wr(SELD_OFS, 32'(t[i][1]));
            u_src.drive(40'h1 << t[i][2], 40'h0);
            arm(8'(t[i][0] * 4), 32'h4, 32'(t[i][3]) << t[i][0], "select");
            check("src_vec", {28'h0, vec_req_o}, 32'(t[i][3]) << t[i][0]);
            wr(8'(t[i][0] * 4), 32'h0);
        end
        $display("select test done");
    endtask

    // Pulse on source 0 of a given length, read the flag once the filter has settled
    task automatic pulse(input logic [31:0] cfg, input int len, input logic e, input string nm);
        wr(CFG0_OFS, cfg);
        wr(FLAG_OFS, 32'hf);
        u_src.drive(40'h100, 40'h0);
        repeat (len - 1) @(posedge clk_i);
        u_src.drive(40'h0, 40'h0);
        repeat (FILT_PULSE_CYC + 8) @(posedge clk_i);
        rd_chk(nm, FLAG_OFS, {31'h0, e});
    endtask

    task automatic t_pulse();
        logic [31:0] q;
        pulse(32'h4, MIN_PULSE_CYC, 1'b1, "short_level");
        pulse(32'h9, 20, 1'b0, "filt_short");
        pulse(32'h9, FILT_PULSE_CYC, 1'b1, "filt_long");
        u_src.drive(40'h0, 40'h100);
        arm(CFG0_OFS, 32'h5, 32'h0, "analog_low");
        arm(CFG0_OFS, 32'h4, 32'h1, "analog_high");
        wb(1'b0, INVIEW_OFS, 32'h0, q);
        check("inview", {31'h0, q[0]}, 32'h1);
        $display("pulse test done");
    endtask

    task automatic t_irq();
        logic [31:0] q;
        u_src.drive(40'h0, 40'h0);
        arm(CFG0_OFS, 32'h1, 32'h0, "irq_arm");
        wb(1'b0, EVSTAT_OFS, 32'h0, q);
        wr(EVMASK_OFS, 32'h1);
        u_src.drive(40'h100, 40'h0);
        repeat (4) @(posedge clk_i);
        check("int_set", {31'h0, int_o}, 32'h1);
        rd_chk("status", EVSTAT_OFS, 32'h1);
        check("int_clr", {31'h0, int_o}, 32'h0);
        wr(FLAG_OFS, 32'h0);
        rd_chk("flag_keep", FLAG_OFS, 32'h1);
        $display("irq test done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        {rst_i, cyc_i, stb_i, we_i} = 4'h8;
        {adr_i, sel_i, dat_i} = {8'h0, 4'hf, 32'h0};
        {err_count, num_checks} = {32'h0, 32'h0};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_modes();
        t_select();
        t_pulse();
        t_irq();
        summarize();
    end

    // The run needs under a thousand cycles; this limit cuts a hang short
    initial begin
        repeat (30000) @(posedge clk_i);
        check("watchdog", 32'h0, 32'h1);
        summarize();
    end
endmodule // tb

bind gei_top gei_properties u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
                                     .ack_o, .pin_in_i, .pin_analog_i, .vec_req_o, .int_o);

// ### verilog/gei_chan.sv
// One source channel: optional filter, edge and level detection
`timescale 1ns/100ps
module gei_chan (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             pin_i,
    input  wire logic             valid_i,
    input  wire gei_pkg::gei_cfg_s cfg_i,
    output logic                  det_o,
    output logic                  seen_o
);
    import gei_pkg::*;

    logic                  samp_ff;
    logic                  filt_ff;
    logic                  prev_ff;
    logic [FILT_CNT_W-1:0] cnt_ff;
    logic [FILT_CNT_W-1:0] nxt_cnt;
    logic                  nxt_filt;
    logic                  cur;
    logic                  rise;
    logic                  fall;
    gei_mode_e             mode;

    // Filter counts differing samples; a short glitch never moves the output.
    // While disabled it follows the sample, so enabling it later raises no false edge
    assign nxt_cnt  = (!cfg_i.filter_enable_bit || samp_ff == filt_ff) ? '0 :
                      (cnt_ff == FILT_CNT_W'(FILT_STABLE - 1)) ? '0 : cnt_ff + 1'b1;
    assign nxt_filt = !cfg_i.filter_enable_bit ? samp_ff :
                      (samp_ff != filt_ff && cnt_ff == FILT_CNT_W'(FILT_STABLE - 1)) ? samp_ff : filt_ff;
    assign cur      = cfg_i.filter_enable_bit ? filt_ff : samp_ff;
    assign rise     = cur & ~prev_ff;
    assign fall     = ~cur & prev_ff;
    assign mode     = gei_mode_e'(cfg_i.trigger_mode_field);
    assign seen_o   = cur;

    // Sample every cycle so a pulse of one period is already caught
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            samp_ff <= 1'b1;
            filt_ff <= 1'b1;
            prev_ff <= 1'b1;
            cnt_ff  <= '0;
        end else begin
            samp_ff <= pin_i;
            filt_ff <= nxt_filt;
            prev_ff <= cur;
            cnt_ff  <= nxt_cnt;
        end
    end

    // Mode decode; codes 6 and 7 act as disabled
    always_comb begin
        det_o = 1'b0;
        unique case (mode)
            GEI_DISABLED: det_o = 1'b0;
            GEI_RISING:   det_o = rise;
            GEI_FALLING:  det_o = fall;
            GEI_BOTH:     det_o = rise | fall;
            GEI_HIGH:     det_o = cur;
            GEI_LOW:      det_o = ~cur;
            default:      det_o = 1'b0;
        endcase
        if (!valid_i) begin
            det_o = 1'b0;
        end
    end

endmodule // gei_chan

// ### verilog/gei_pkg.sv
// Package with constants and types of the external interrupt unit
// Behaviour
// - Four independent sources each drive their own vector request toward the processor.
// - Sources watch the ordinary input path, so a pin used by a peripheral or as output still works.
// - Only an analog pin is unusable as a source; every other configuration is usable.
// - An analog pin reads as logic high to the interrupt logic.
// - A trigger mode field of 0 disables, 1..5 select rising, falling, both, high level, low level.
// - Without the filter any pulse or level of at least 80 ns is latched.
// - The filter enable bit inserts a digital filter; then 450 ns events are surely latched.
// - The pending flag register clears a bit on write 1 and ignores write 0.
// - In level mode a flag cleared while the input is active comes back on the next cycle; the unit keeps it set, as the detection wins over the clear.
// - The first source is fixed to port B pin 0 and the second to port B pin 6.
// - Third and fourth sources pick a pin by code: 0-7 A, 8-15 B, 16-23 C, 25-28 D1-4, 32-35 E0-3.
package gei_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int MIN_PULSE_NS   = 80;
    localparam int FILT_PULSE_NS  = 450;
    localparam int MIN_PULSE_CYC  = (MIN_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 : MIN_PULSE_NS / CLK_PERIOD_NS;
    localparam int FILT_PULSE_CYC = (FILT_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 : FILT_PULSE_NS / CLK_PERIOD_NS;
    // Filter needs this many equal samples; margin of four cycles for sampling skew
    localparam int FILT_STABLE    = FILT_PULSE_CYC - 4;
    localparam int FILT_CNT_W     = $clog2(FILT_STABLE + 1);

    // Sizes
    localparam int NUM_SRC  = 4;
    localparam int NUM_PINS = 40;
    localparam int SEL_W    = 6;

    // Fixed pins and selection map
    localparam logic [SEL_W-1:0] PORT_B_PIN_0_IDX = 6'h08;
    localparam logic [SEL_W-1:0] PORT_B_PIN_6_IDX = 6'h0e;
    localparam logic [SEL_W-1:0] SEL_C_LAST       = 6'h17;
    localparam logic [SEL_W-1:0] SEL_D_FIRST      = 6'h19;
    localparam logic [SEL_W-1:0] SEL_D_LAST       = 6'h1c;
    localparam logic [SEL_W-1:0] SEL_E_FIRST      = 6'h20;
    localparam logic [SEL_W-1:0] SEL_E_LAST       = 6'h23;

    // Register byte offsets
    localparam logic [7:0] CFG0_OFS    = 8'h00;
    localparam logic [7:0] CFG1_OFS    = 8'h04;
    localparam logic [7:0] CFG2_OFS    = 8'h08;
    localparam logic [7:0] CFG3_OFS    = 8'h0c;
    localparam logic [7:0] SELC_OFS    = 8'h10;
    localparam logic [7:0] SELD_OFS    = 8'h14;
    localparam logic [7:0] FLAG_OFS    = 8'h18;
    localparam logic [7:0] EVSTAT_OFS  = 8'h1c;
    localparam logic [7:0] EVMASK_OFS  = 8'h20;
    localparam logic [7:0] INVIEW_OFS  = 8'h24;

    // Field positions and reset values
    localparam int          CFG_MODE_LSB  = 0;
    localparam int          CFG_FILT_BIT  = 3;
    localparam logic [3:0]  CFG_RST       = 4'h0;
    localparam logic [SEL_W-1:0] SEL_RST  = 6'h00;
    localparam logic [3:0]  FLAG_RST      = 4'h0;
    localparam logic [3:0]  MASK_RST      = 4'h0;

    // Trigger modes in register order
    typedef enum logic [2:0] {
        GEI_DISABLED,
        GEI_RISING,
        GEI_FALLING,
        GEI_BOTH,
        GEI_HIGH,
        GEI_LOW
    } gei_mode_e;

    // Source configuration as stored
    typedef struct packed {
        logic       filter_enable_bit;
        logic [2:0] trigger_mode_field;
    } gei_cfg_s;

endpackage

// ### verilog/gei_top.sv
// External interrupt unit with classic Wishbone register slave
`timescale 1ns/100ps
module gei_top (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Wishbone slave
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [7:0]                    adr_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [31:0]                   dat_i,
    output logic [31:0]                        dat_o,
    output logic                               ack_o,
    // Pin inputs from the ordinary input path, index port*8+pin
    input  wire logic [gei_pkg::NUM_PINS-1:0]  pin_in_i,
    input  wire logic [gei_pkg::NUM_PINS-1:0]  pin_analog_i,
    // Vector requests and summary interrupt
    output logic [gei_pkg::NUM_SRC-1:0]        vec_req_o,
    output logic                               int_o
);
    import gei_pkg::*;

    // Registers
    gei_cfg_s           cfg_ff [NUM_SRC];
    logic [SEL_W-1:0]   third_source_pin_select_ff;
    logic [SEL_W-1:0]   fourth_source_pin_select_ff;
    logic [NUM_SRC-1:0] pending_flag_register_ff;
    logic [NUM_SRC-1:0] evstat_ff;
    logic [NUM_SRC-1:0] evmask_ff;
    logic [NUM_SRC-1:0] vec_ff;
    logic               ack_ff;
    logic [31:0]        dat_ff;

    // Next values
    logic [NUM_SRC-1:0] nxt_flag;
    logic [NUM_SRC-1:0] nxt_evstat;
    logic [NUM_SRC-1:0] nxt_vec;
    logic [31:0]        nxt_dat;

    // Bus decode
    wire                bus_req  = cyc_i & stb_i & ~ack_ff;
    wire                wr_en    = bus_req & we_i & sel_i[0];
    wire                rd_en    = bus_req & ~we_i;
    wire                wr_cfg0  = wr_en & (adr_i == CFG0_OFS);
    wire                wr_cfg1  = wr_en & (adr_i == CFG1_OFS);
    wire                wr_cfg2  = wr_en & (adr_i == CFG2_OFS);
    wire                wr_cfg3  = wr_en & (adr_i == CFG3_OFS);
    wire                wr_selc  = wr_en & (adr_i == SELC_OFS);
    wire                wr_seld  = wr_en & (adr_i == SELD_OFS);
    wire                wr_flag  = wr_en & (adr_i == FLAG_OFS);
    wire                wr_mask  = wr_en & (adr_i == EVMASK_OFS);
    wire                rd_stat  = rd_en & (adr_i == EVSTAT_OFS);

    // Channel signals
    logic [NUM_PINS-1:0] pin_dig;
    logic [NUM_SRC-1:0]  src_pin;
    logic [NUM_SRC-1:0]  src_valid;
    logic [NUM_SRC-1:0]  det;
    logic [NUM_SRC-1:0]  seen;
    logic [NUM_SRC-1:0]  mode_on;
    logic [NUM_SRC-1:0]  flag_clr;
    logic [NUM_SRC-1:0]  flag_new;
    wire                 valid_c;
    wire                 valid_d;

    // Analog pins look high; every other configuration passes the pin
    assign pin_dig = pin_in_i | pin_analog_i;

    // Selection map for the third and fourth sources
    assign valid_c = (third_source_pin_select_ff <= SEL_C_LAST) ||
                     (third_source_pin_select_ff >= SEL_D_FIRST &&
                      third_source_pin_select_ff <= SEL_D_LAST) ||
                     (third_source_pin_select_ff >= SEL_E_FIRST &&
                      third_source_pin_select_ff <= SEL_E_LAST);
    assign valid_d = (fourth_source_pin_select_ff <= SEL_C_LAST) ||
                     (fourth_source_pin_select_ff >= SEL_D_FIRST &&
                      fourth_source_pin_select_ff <= SEL_D_LAST) ||
                     (fourth_source_pin_select_ff >= SEL_E_FIRST &&
                      fourth_source_pin_select_ff <= SEL_E_LAST);

    // Out-of-range codes read a constant and are also gated in the channel
    assign src_pin[0]   = pin_dig[PORT_B_PIN_0_IDX];
    assign src_pin[1]   = pin_dig[PORT_B_PIN_6_IDX];
    assign src_pin[2]   = valid_c ? pin_dig[third_source_pin_select_ff] : 1'b1;
    assign src_pin[3]   = valid_d ? pin_dig[fourth_source_pin_select_ff] : 1'b1;
    assign src_valid    = {valid_d, valid_c, 2'b11};

    // One channel per source, each independent
    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
            gei_chan u_chan (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .pin_i   (src_pin[g]),
                .valid_i (src_valid[g]),
                .cfg_i   (cfg_ff[g]),
                .det_o   (det[g]),
                .seen_o  (seen[g])
            );
            assign mode_on[g] = (cfg_ff[g].trigger_mode_field != 3'h0);
        end
    endgenerate

    // Flag update: a detection in the clearing cycle wins over the clear
    assign flag_clr = wr_flag ? dat_i[NUM_SRC-1:0] : '0;
    assign nxt_flag = (pending_flag_register_ff & ~flag_clr) | det;
    assign flag_new = det & ~pending_flag_register_ff;

    // Event status: a newly pending source is sticky until read
    assign nxt_evstat = (rd_stat ? '0 : evstat_ff) | flag_new;

    // Vector request stands while flag is set and the trigger mode field is nonzero (codes 6 and 7 included)
    assign nxt_vec = nxt_flag & mode_on;

    // Read mux; unmapped addresses read zero
    always_comb begin
        nxt_dat = 32'h0;
        unique case (adr_i)
            CFG0_OFS:   nxt_dat[3:0] = cfg_ff[0];
            CFG1_OFS:   nxt_dat[3:0] = cfg_ff[1];
            CFG2_OFS:   nxt_dat[3:0] = cfg_ff[2];
            CFG3_OFS:   nxt_dat[3:0] = cfg_ff[3];
            SELC_OFS:   nxt_dat[SEL_W-1:0] = third_source_pin_select_ff;
            SELD_OFS:   nxt_dat[SEL_W-1:0] = fourth_source_pin_select_ff;
            FLAG_OFS:   nxt_dat[NUM_SRC-1:0] = pending_flag_register_ff;
            EVSTAT_OFS: nxt_dat[NUM_SRC-1:0] = evstat_ff;
            EVMASK_OFS: nxt_dat[NUM_SRC-1:0] = evmask_ff;
            INVIEW_OFS: nxt_dat[NUM_SRC-1:0] = seen;
            default:    nxt_dat = 32'h0;
        endcase
    end

    // Bus handshake: ack one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end else begin
            ack_ff <= bus_req;
            dat_ff <= rd_en ? nxt_dat : dat_ff;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff[0] <= CFG_RST;
            cfg_ff[1] <= CFG_RST;
            cfg_ff[2] <= CFG_RST;
            cfg_ff[3] <= CFG_RST;
        end else begin
            if (wr_cfg0) cfg_ff[0] <= dat_i[3:0];
            if (wr_cfg1) cfg_ff[1] <= dat_i[3:0];
            if (wr_cfg2) cfg_ff[2] <= dat_i[3:0];
            if (wr_cfg3) cfg_ff[3] <= dat_i[3:0];
        end
    end

    // Pin selection registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            third_source_pin_select_ff  <= SEL_RST;
            fourth_source_pin_select_ff <= SEL_RST;
        end else begin
            if (wr_selc) third_source_pin_select_ff  <= dat_i[SEL_W-1:0];
            if (wr_seld) fourth_source_pin_select_ff <= dat_i[SEL_W-1:0];
        end
    end

    // Mask register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evmask_ff <= MASK_RST;
        end else if (wr_mask) begin
            evmask_ff <= dat_i[NUM_SRC-1:0];
        end
    end

    // Pending flags, event status and vector requests
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_flag_register_ff <= FLAG_RST;
            evstat_ff                <= FLAG_RST;
            vec_ff                   <= FLAG_RST;
        end else begin
            pending_flag_register_ff <= nxt_flag;
            evstat_ff                <= nxt_evstat;
            vec_ff                   <= nxt_vec;
        end
    end

    // Outputs
    assign dat_o     = dat_ff;
    assign ack_o     = ack_ff;
    assign vec_req_o = vec_ff;
    assign int_o     = |(evstat_ff & evmask_ff);

endmodule // gei_top
